// File: pkg/mrw_pkg.sv
package mrw_pkg;

  // ----------------------------------------------------------------------
  // Clock and time base
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 25_000_000;
  localparam int unsigned HALF_SEC_MS   = 500;
  // Cycles in one half-second tick
  localparam int unsigned HALF_SEC_CYC  = (CLK_HZ / 1000) * HALF_SEC_MS;

  // ----------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [11:0] OFS_CTRL    = 12'h000;
  localparam logic [11:0] OFS_STAGE   = 12'h004;
  localparam logic [11:0] OFS_TRIG    = 12'h008;
  localparam logic [11:0] OFS_STATUS  = 12'h00C;
  localparam logic [11:0] OFS_IRQ_ST  = 12'h010;
  localparam logic [11:0] OFS_IRQ_MSK = 12'h014;

  // Trigger key written to the trigger register
  localparam logic [31:0] TRIG_KEY    = 32'h0000_5A5A;

  // Reset values
  localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
  localparam logic [31:0] STAGE_RST   = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // Timeout codes in half-second ticks
  // ----------------------------------------------------------------------
  localparam int unsigned NUM_PERIODS = 11;
  localparam logic [3:0]  PER_MAX     = 4'hA;
  localparam logic [3:0]  DLY_MAX     = 4'h7;
  localparam logic [2:0]  POST_MAX    = 3'h6;

  // Action codes per stage; stage 1 has no disabled code
  localparam logic [2:0] ACT_NONE = 3'h0;
  localparam logic [2:0] ACT_NMI  = 3'h1;
  localparam logic [2:0] ACT_ACPI = 3'h2;
  localparam logic [2:0] ACT_RST  = 3'h3;
  localparam logic [2:0] ACT_PWR  = 3'h4;

  typedef enum logic [1:0] {
    MRW_MODE_ONCE,
    MRW_MODE_SINGLE,
    MRW_MODE_REPEAT,
    MRW_MODE_RSVD
  } mrw_mode_t;

  // Event pulses towards the system
  typedef struct packed {
    logic nmi;
    logic rst;
    logic pwr;
    logic acpi_temp;
    logic acpi_fatal;
  } mrw_evt_t;

  // APB request bundle
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } mrw_apb_req_t;

  // Half-second tick count of each timeout code
  function automatic logic [11:0] mrw_ticks(input logic [3:0] code);
    logic [11:0] t;
    t = 12'h001;
    unique case (code)
      4'h0: t = 12'h001;
      4'h1: t = 12'h002;
      4'h2: t = 12'h004;
      4'h3: t = 12'h00A;
      4'h4: t = 12'h014;
      4'h5: t = 12'h03C;
      4'h6: t = 12'h078;
      4'h7: t = 12'h0F0;
      4'h8: t = 12'h258;
      4'h9: t = 12'h4B0;
      4'hA: t = 12'hE10;
      default: t = 12'hE10;
    endcase
    return t;
  endfunction

endpackage

// File: hdl/mrw_watchdog.sv
// Local design decisions: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - Boot watchdog off or 30 s..30 min
// - Runtime watchdog armed only at OS start
// - One-time mode stops after first trigger
// - Single mode fires each stage once, stops
// - Repeat mode reruns last stage until reset
// - Start delay none, 10 s..30 min
// - Stage one always fires its action
// - Stage two fires action unless disabled
// - Stage three fires action unless it or stage two is disabled
// - Stage one timeout 0.5 s..30 min
// - Stage two uses same timeout set
// - Stage three uses same timeout set
// - ACPI action selects shutdown or restart
// - Shutdown sent as over-temperature notice
// - Restart sent as fatal-error report
module mrw_watchdog
  import mrw_pkg::*;
#(
  parameter int unsigned TICK_CYC = mrw_pkg::HALF_SEC_CYC
)(
  input  wire logic        clk_i,      // 25 MHz clock
  input  wire logic        rst_i,      // Sync reset, high
  input  wire logic        ce_i,       // Clock enable
  input  wire logic        psel_i,     // APB select
  input  wire logic        penable_i,  // APB enable
  input  wire logic        pwrite_i,   // APB write
  input  wire logic [11:0] paddr_i,    // APB byte address
  input  wire logic [31:0] pwdata_i,   // APB write data
  output logic      [31:0] prdata_o,   // APB read data
  output logic             pready_o,   // APB ready
  output logic             pslverr_o,  // APB error
  input  wire logic        os_boot_i,  // Pulse: OS starts booting
  output logic             nmi_o,      // NMI pulse
  output logic             reset_o,    // System reset pulse
  output logic             pwrbtn_o,   // Power-button pulse
  output logic             acpi_tmp_o, // Over-temperature pulse
  output logic             acpi_err_o, // Fatal-error pulse
  output logic             irq_o       // Level interrupt
);
  import mrw_pkg::*;

  // Refuse tick lengths that the 28-bit prescaler cannot hold
  if (TICK_CYC < 2 || TICK_CYC > 32'h0FFF_FFFF)
  begin
    $error("TICK_CYC out of range");
  end

  // ----------------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------------
  logic [31:0] ctrl_reg;
  logic [31:0] stage_reg;
  logic [2:0]  irq_st_reg;
  logic [2:0]  irq_msk_reg;
  mrw_apb_req_t req;

  assign req = '{psel_i, penable_i, pwrite_i, paddr_i, pwdata_i};

  // Only the first access edge acts: a second pass would clear status
  // bits set while the read data was already on its way out
  wire acc      = req.psel && req.penable && !pready_o;
  wire wr       = acc && req.pwrite;
  wire rd       = acc && !req.pwrite;
  wire hit_ctrl = req.paddr == OFS_CTRL;
  wire hit_stg  = req.paddr == OFS_STAGE;
  wire hit_trg  = req.paddr == OFS_TRIG;
  wire hit_sts  = req.paddr == OFS_STATUS;
  wire hit_ist  = req.paddr == OFS_IRQ_ST;
  wire hit_msk  = req.paddr == OFS_IRQ_MSK;
  wire hit_any  = hit_ctrl | hit_stg | hit_trg | hit_sts | hit_ist | hit_msk;

  // Control fields: [2:0] post code, [3] post enable, [5:4] mode,
  // [9:6] delay code, [10] acpi restart select
  wire [2:0]  post_code = ctrl_reg[2:0];
  wire        post_en   = ctrl_reg[3];
  mrw_mode_t  mode;
  assign mode = mrw_mode_t'(ctrl_reg[5:4]);
  wire [3:0]  dly_code  = ctrl_reg[9:6];
  wire        acpi_rst  = ctrl_reg[10];
  // Stage fields: per stage a 4-bit timeout and a 3-bit action
  wire [3:0]  tmo [3];
  wire [2:0]  act [3];
  assign tmo[0] = stage_reg[3:0];
  assign tmo[1] = stage_reg[11:8];
  assign tmo[2] = stage_reg[19:16];
  assign act[0] = stage_reg[6:4];
  assign act[1] = stage_reg[14:12];
  assign act[2] = stage_reg[22:20];

  wire trig = wr && hit_trg && (req.pwdata == TRIG_KEY);

  // ----------------------------------------------------------------------
  // Half-second tick
  // ----------------------------------------------------------------------
  logic [27:0] pre_reg;
  wire         tick = pre_reg == 28'(TICK_CYC - 1);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pre_reg <= '0;
    else if (ce_i)
      pre_reg <= tick ? '0 : pre_reg + 28'h000_0001;
  end

  // ----------------------------------------------------------------------
  // Boot watchdog: runs from reset until the OS boot strobe or its own expiry
  // ----------------------------------------------------------------------
  // Post codes map to timeout codes 30s,1m,2m,5m,10m,30m
  function automatic logic [3:0] post_map(input logic [2:0] c);
    return (c > 3'h5) ? PER_MAX : 4'(c) + 4'h5;
  endfunction

  logic        post_run_reg;
  logic [11:0] post_cnt_reg;
  wire         post_exp = post_run_reg && post_en && tick &&
                 post_cnt_reg + 12'h001 >= mrw_ticks(post_map(post_code));

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      post_run_reg <= 1'b1;
      post_cnt_reg <= '0;
    end
    else if (ce_i)
    begin
      if (os_boot_i || post_exp)
        post_run_reg <= 1'b0;
      if (tick)
        post_cnt_reg <= post_cnt_reg + 12'h001;
    end
  end

  // ----------------------------------------------------------------------
  // Runtime watchdog sequencer
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {ST_IDLE, ST_DELAY, ST_RUN, ST_DONE} mrw_st_t;
  mrw_st_t     st_reg;
  mrw_st_t     st_next;
  logic [1:0]  stg_reg;
  logic [1:0]  stg_next;
  logic [11:0] cnt_reg;
  logic [11:0] cnt_next;

  wire [11:0] dly_lim = mrw_ticks(dly_code + 4'h3);
  wire [11:0] stg_lim = mrw_ticks(tmo[stg_reg]);
  wire        stg_exp = st_reg == ST_RUN && tick &&
                        cnt_reg + 12'h001 >= stg_lim;
  // Stage one cannot be silenced: none or an unknown code gives NMI
  wire [2:0]  act0_ok = (act[0] == ACT_NONE || act[0] > ACT_PWR) ?
                        ACT_NMI : act[0];
  wire [2:0]  cur_act = (stg_reg == 2'h0) ? act0_ok : act[stg_reg];
  // Last stage is the one before the first disabled stage
  wire        nxt_ok  = stg_reg != 2'h2 &&
                        act[stg_reg + 2'h1] != ACT_NONE;
  wire        fire    = stg_exp && (stg_reg == 2'h0 ||
                        cur_act != ACT_NONE);

  always_comb
  begin
    st_next  = st_reg;
    stg_next = stg_reg;
    cnt_next = tick ? cnt_reg + 12'h001 : cnt_reg;
    unique case (st_reg)
      ST_IDLE:
        if (os_boot_i)
        begin
          st_next  = (dly_code == 4'h0) ? ST_RUN : ST_DELAY;
          cnt_next = '0;
          stg_next = '0;
        end
      ST_DELAY:
        if (tick && cnt_reg + 12'h001 >= dly_lim)
        begin
          st_next  = ST_RUN;
          cnt_next = '0;
        end
      ST_RUN:
        if (trig)
        begin
          cnt_next = '0;
          stg_next = '0;
          if (mode == MRW_MODE_ONCE)
            st_next = ST_DONE;
        end
        else if (stg_exp)
        begin
          cnt_next = '0;
          if (nxt_ok)
            stg_next = stg_reg + 2'h1;
          else if (mode == MRW_MODE_REPEAT)
            stg_next = stg_reg;
          else
            st_next = ST_DONE;
        end
      ST_DONE:
        st_next = ST_DONE;
      default:
        st_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_reg  <= ST_IDLE;
      stg_reg <= '0;
      cnt_reg <= '0;
    end
    else if (ce_i)
    begin
      st_reg  <= st_next;
      stg_reg <= stg_next;
      cnt_reg <= cnt_next;
    end
  end

  // ----------------------------------------------------------------------
  // Event outputs, one-cycle pulses
  // ----------------------------------------------------------------------
  wire [2:0] fire_act = post_exp ? ACT_RST : (fire ? cur_act : ACT_NONE);
  mrw_evt_t  evt;
  assign evt.nmi        = fire_act == ACT_NMI;
  assign evt.rst        = fire_act == ACT_RST;
  assign evt.pwr        = fire_act == ACT_PWR;
  assign evt.acpi_temp  = fire_act == ACT_ACPI && !acpi_rst;
  assign evt.acpi_fatal = fire_act == ACT_ACPI && acpi_rst;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      nmi_o      <= 1'b0;
      reset_o    <= 1'b0;
      pwrbtn_o   <= 1'b0;
      acpi_tmp_o <= 1'b0;
      acpi_err_o <= 1'b0;
    end
    else if (ce_i)
    begin
      nmi_o      <= evt.nmi;
      reset_o    <= evt.rst;
      pwrbtn_o   <= evt.pwr;
      acpi_tmp_o <= evt.acpi_temp;
      acpi_err_o <= evt.acpi_fatal;
    end
  end

  // ----------------------------------------------------------------------
  // Registers, interrupt status and read data
  // ----------------------------------------------------------------------
  // Status events: [0] runtime fire, [1] boot expiry, [2] runtime done
  wire [2:0] ev_set = {st_next == ST_DONE && st_reg != ST_DONE,
                       post_exp, fire};
  wire [31:0] sts_word = {24'h0, 1'b0, post_run_reg, stg_reg,
                          1'b0, 3'(st_reg)};
  wire [31:0] rd_word =
    hit_ctrl ? ctrl_reg :
    hit_stg  ? stage_reg :
    hit_sts  ? sts_word :
    hit_ist  ? {29'h0, irq_st_reg} :
    hit_msk  ? {29'h0, irq_msk_reg} : 32'h0;

  // Configuration is locked once the runtime watchdog is armed
  wire cfg_wr = wr && st_reg == ST_IDLE;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_reg    <= CTRL_RST;
      stage_reg   <= STAGE_RST;
      irq_st_reg  <= '0;
      irq_msk_reg <= '0;
      prdata_o    <= '0;
      pready_o    <= 1'b0;
      pslverr_o   <= 1'b0;
      irq_o       <= 1'b0;
    end
    else if (ce_i)
    begin
      if (cfg_wr && hit_ctrl)
        ctrl_reg <= req.pwdata;
      if (cfg_wr && hit_stg)
        stage_reg <= req.pwdata;
      if (wr && hit_msk)
        irq_msk_reg <= req.pwdata[2:0];
      // Set wins over the read clear
      irq_st_reg <= (rd && hit_ist ? 3'h0 : irq_st_reg) | ev_set;
      prdata_o   <= rd ? rd_word : 32'h0;
      pready_o   <= acc && !pready_o;
      pslverr_o  <= acc && !pready_o && !hit_any;
      irq_o      <= |(((rd && hit_ist) ? 3'h0 : irq_st_reg)
                      & irq_msk_reg) | |(ev_set & irq_msk_reg);
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Arming, modes and the chain of stages
  arm_on_boot_a: assert property
    (st_reg == ST_IDLE && ce_i && !os_boot_i |=> st_reg == ST_IDLE)
    else $error("armed without boot");
  once_stop_a: assert property
    (st_reg == ST_RUN && trig && ce_i && mode == MRW_MODE_ONCE
      |=> st_reg == ST_DONE) else $error("one-time not stopped");
  single_end_a: assert property
    (stg_exp && ce_i && !trig && !nxt_ok && mode == MRW_MODE_SINGLE
      |=> st_reg == ST_DONE) else $error("single not stopped");
  repeat_last_a: assert property
    (stg_exp && ce_i && !trig && !nxt_ok && mode == MRW_MODE_REPEAT
      |=> st_reg == ST_RUN && $stable(stg_reg))
    else $error("repeat left last stage");
  delay_hold_a: assert property
    (st_reg == ST_DELAY && ce_i && cnt_reg + 12'h001 < dly_lim
      |=> st_reg == ST_DELAY) else $error("delay cut short");
  boot_exp_a: assert property
    (post_exp && ce_i |=> reset_o && !post_run_reg)
    else $error("boot expiry lost");
  cfg_lock_a: assert property
    (st_reg != ST_IDLE && ce_i |=> $stable(ctrl_reg) && $stable(stage_reg))
    else $error("config changed while armed");
  // Actions of each stage
  stage_one_a: assert property
    (stg_exp && stg_reg == 2'h0 && ce_i && !post_exp |=> nmi_o | reset_o
      | pwrbtn_o | acpi_tmp_o | acpi_err_o) else $error("stage one silent");
  stage_two_a: assert property
    (stg_exp && stg_reg == 2'h1 && ce_i && !post_exp && cur_act != ACT_NONE
      && cur_act <= ACT_PWR |=> nmi_o | reset_o | pwrbtn_o | acpi_tmp_o
      | acpi_err_o) else $error("stage two silent");
  stage_three_a: assert property
    (stg_exp && stg_reg == 2'h2 && ce_i && !post_exp && cur_act != ACT_NONE
      && cur_act <= ACT_PWR |=> nmi_o | reset_o | pwrbtn_o | acpi_tmp_o
      | acpi_err_o) else $error("stage three silent");
  acpi_temp_a: assert property
    (fire && !post_exp && ce_i && cur_act == ACT_ACPI && !acpi_rst
      |=> acpi_tmp_o && !acpi_err_o) else $error("shutdown path wrong");
  acpi_fatal_a: assert property
    (fire && !post_exp && ce_i && cur_act == ACT_ACPI && acpi_rst
      |=> acpi_err_o && !acpi_tmp_o) else $error("restart path wrong");
  stage_zero_a: assert property
    (stg_exp && ce_i && !trig |=> cnt_reg == 12'h000)
    else $error("stage timer not zeroed");
  trig_restart_a: assert property
    (st_reg == ST_RUN && trig && ce_i |=> stg_reg == 2'h0 &&
      cnt_reg == 12'h000) else $error("trigger did not restart");
  chain_end_a: assert property
    (stg_reg != 2'h0 && st_reg == ST_RUN |-> act[stg_reg] != ACT_NONE)
    else $error("ran disabled stage");
  // Bus answer and interrupt level
  ready_pulse_a: assert property
    (pready_o && ce_i |=> !pready_o) else $error("ready held");
  irq_level_a: assert property
    (|(irq_st_reg & irq_msk_reg) && ce_i && !(rd && hit_ist) |=> irq_o)
    else $error("irq not raised");

  // Main scenarios worth seeing in a run
  fire_cov: cover property (fire ##[1:300] fire);
  trig_cov: cover property (st_reg == ST_RUN && trig);
  done_cov: cover property (st_reg == ST_DONE);
  post_cov: cover property (post_exp);
  repeat_cov: cover property (stg_exp && !nxt_ok && mode == MRW_MODE_REPEAT);

endmodule
`default_nettype wire

// File: testbench/mrw_sys_model.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------------
// System interrupt and reset logic: counts the events it receives
// ----------------------------------------------------------------------
module mrw_sys_model
  import mrw_pkg::*;
(
  input  wire logic              clk_i,    // System clock
  input  wire logic              clr_i,    // Clear all counts
  input  wire mrw_pkg::mrw_evt_t evt_i,    // Event pulses
  output logic [7:0]             cnt_o [5] // High cycles per line
);
  // Counts high cycles, not edges, so a stretched pulse shows up as
  // a second event; saturates to keep a runaway repeat readable
  always_ff @(posedge clk_i)
  begin
    for (int i = 0; i < 5; i++)
    begin
      if (clr_i)
        cnt_o[i] <= 8'h00;
      else if (evt_i[i] && cnt_o[i] != 8'hFF)
        cnt_o[i] <= cnt_o[i] + 8'h01;
    end
  end
endmodule
`default_nettype wire

// File: testbench/tb_multistage_runtime_watchdog.sv
`timescale 1ns/1ns
`default_nettype none
module tb_multistage_runtime_watchdog
  import mrw_pkg::*;
;
  // --------------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------------
  localparam int NMI = 4, RST = 3, PWR = 2, TMP = 1, ERR = 0;
  logic         clk_i = 1'b0;
  logic         rst_i = 1'b1;
  logic         ce_i = 1'b1;
  logic         os_boot_i = 1'b0;
  mrw_apb_req_t req = '0;
  logic [31:0]  prdata_o, rd;
  logic         pready_o, pslverr_o, er, irq_o;
  logic         nmi_o, reset_o, pwrbtn_o, acpi_tmp_o, acpi_err_o;
  mrw_evt_t     evt;
  logic [7:0]   cnt [5];
  int           error_cnt = 0;
  int           samples_checked = 0;

  // Clock, event bundle and the two sides of the block
  always #20 clk_i = ~clk_i;
  assign evt = '{nmi: nmi_o, rst: reset_o, pwr: pwrbtn_o,
                 acpi_temp: acpi_tmp_o, acpi_fatal: acpi_err_o};
  mrw_watchdog #(.TICK_CYC (4)) dut (
    .clk_i (clk_i), .rst_i (rst_i), .ce_i (ce_i),
    .psel_i (req.psel), .penable_i (req.penable),
    .pwrite_i (req.pwrite), .paddr_i (req.paddr),
    .pwdata_i (req.pwdata), .prdata_o (prdata_o),
    .pready_o (pready_o), .pslverr_o (pslverr_o),
    .os_boot_i (os_boot_i), .nmi_o (nmi_o), .reset_o (reset_o),
    .pwrbtn_o (pwrbtn_o), .acpi_tmp_o (acpi_tmp_o),
    .acpi_err_o (acpi_err_o), .irq_o (irq_o));
  mrw_sys_model u_sys (.clk_i (clk_i), .clr_i (rst_i), .evt_i (evt),
                       .cnt_o (cnt));

  // --------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input bit ok, input string m);
    samples_checked++;
    if (!ok)
    begin
      error_cnt++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk_i);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk_i);
    req.penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    rd = prdata_o;
    er = pslverr_o;
    req <= '0;
    chk(n < 50, "no pready");
  endtask

  task automatic rst_dut();
    @(posedge clk_i);
    rst_i <= 1'b1;
    cyc(16);
    rst_i <= 1'b0;
  endtask

  task automatic boot();
    @(posedge clk_i);
    os_boot_i <= 1'b1;
    @(posedge clk_i);
    os_boot_i <= 1'b0;
  endtask

  task automatic start(input logic [31:0] c, input logic [31:0] s);
    rst_dut();
    apb(1'b1, OFS_CTRL, c);
    apb(1'b1, OFS_STAGE, s);
    boot();
  endtask

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  task automatic t_regs();
    rst_dut();
    apb(1'b0, OFS_CTRL, 32'h0);
    chk(rd === CTRL_RST && er === 1'b0, "ctrl reset value");
    apb(1'b1, OFS_STAGE, 32'h0044_2313);
    apb(1'b0, OFS_STAGE, 32'h0);
    chk(rd === 32'h0044_2313, "stage readback");
    apb(1'b0, 12'h020, 32'h0);
    chk(er === 1'b1, "unmapped not refused");
  endtask

  // Boot dog 30 s is 60 ticks of 4 cycles
  task automatic t_boot();
    rst_dut();
    apb(1'b1, OFS_IRQ_MSK, 32'h2);
    apb(1'b1, OFS_CTRL, 32'h8);
    cyc(190);
    chk(cnt[RST] === 8'h00, "boot dog early");
    cyc(120);
    chk(cnt[RST] !== 8'h00 && irq_o === 1'b1, "boot dog silent");
    apb(1'b0, OFS_IRQ_ST, 32'h0);
    chk(rd[1] === 1'b1, "boot expiry status");
  endtask

  // NMI, ACPI shutdown, power button, each once, then done
  task automatic t_single();
    start(32'h10, 32'h0040_2010);
    cyc(150);
    chk(cnt[NMI] === 8'h01, "stage one action");
    chk(cnt[TMP] === 8'h01 && cnt[ERR] === 8'h00, "acpi shutdown");
    chk(cnt[PWR] === 8'h01, "stage three action");
    chk(cnt[RST] === 8'h00, "stray reset");
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd[2:0] === 3'h3, "not done");
  endtask

  // ACPI restart, then reset repeats; stage three off ends chain
  task automatic t_repeat();
    start(32'h0000_0420, 32'h0000_3020);
    cyc(150);
    chk(cnt[ERR] === 8'h01 && cnt[TMP] === 8'h00, "acpi restart");
    chk(cnt[RST] > 8'h04, "last stage not repeated");
    chk(cnt[NMI] === 8'h00 && cnt[PWR] === 8'h00, "past end");
  endtask

  task automatic t_once();
    start(32'h0, 32'h0000_0011);
    apb(1'b1, OFS_TRIG, TRIG_KEY);
    cyc(200);
    chk(cnt[NMI] === 8'h00, "one-time still armed");
  endtask

  // Triggers faster than the 4 tick timeout keep stage one quiet
  task automatic t_trig();
    start(32'h10, 32'h0000_4212);
    apb(1'b1, OFS_IRQ_MSK, 32'h1);
    for (int i = 0; i < 8; i++)
    begin
      apb(1'b1, OFS_TRIG, TRIG_KEY);
      cyc(3);
    end
    chk(cnt[NMI] === 8'h00, "trigger ignored");
    cyc(150);
    chk(cnt[NMI] === 8'h01 && cnt[PWR] === 8'h01, "chain");
    chk(irq_o === 1'b1, "irq low");
    apb(1'b0, OFS_IRQ_ST, 32'h0);
    chk(rd[0] === 1'b1, "fire status");
    cyc(2);
    chk(irq_o === 1'b0, "irq not cleared");
  endtask

  // 10 s delay is 80 cycles; config locked; clock enable freezes
  task automatic t_delay();
    rst_dut();
    apb(1'b1, OFS_CTRL, 32'h50);
    apb(1'b1, OFS_STAGE, 32'h10);
    cyc(100);
    chk(cnt[NMI] === 8'h00, "armed before boot");
    boot();
    apb(1'b1, OFS_CTRL, 32'h0);
    apb(1'b0, OFS_CTRL, 32'h0);
    chk(rd === 32'h50, "config not locked");
    @(posedge clk_i);
    ce_i <= 1'b0;
    cyc(200);
    chk(cnt[NMI] === 8'h00, "ran while frozen");
    ce_i <= 1'b1;
    cyc(40);
    chk(cnt[NMI] === 8'h00, "delay too short");
    cyc(80);
    chk(cnt[NMI] === 8'h01, "delay too long");
  endtask

  // 30 min is 3600 ticks, 14400 cycles
  task automatic t_long();
    start(32'h10, 32'h0000_001A);
    cyc(14300);
    chk(cnt[NMI] === 8'h00, "30 min early");
    cyc(300);
    chk(cnt[NMI] === 8'h01, "30 min late");
  endtask

  // --------------------------------------------------------------------
  // Main sequence and watchdog
  // --------------------------------------------------------------------
  initial
  begin
    rst_dut();
    t_regs();
    t_boot();
    t_single();
    t_repeat();
    t_once();
    t_trig();
    t_delay();
    t_long();
    tally_and_finish();
  end

  // Run needs about 16k cycles; a hang ends well past that
  initial
  begin
    #2_000_000;
    error_cnt++;
    $display("[FAIL] %0t run hung", $time);
    tally_and_finish();
  end
endmodule
`default_nettype wire
